// ---- rtl/cmsl_regs.svh ----
`ifndef CMSL_REGS_SVH
`define CMSL_REGS_SVH
// ***************************************************************
// Image layout
// ***************************************************************
`define CMSL_MEM_AW        13
`define CMSL_DATA_W        8
`define CMSL_CODE_BYTES    4096
`define CMSL_KEY_BYTES     64
`define CMSL_KEY_BASE      13'h1000
`define CMSL_OPT_ADDR      13'h1040
`define CMSL_ERASED_BYTE   8'hFF
`define CMSL_BLOCKED_BYTE  8'h00
// ***************************************************************
// Option byte fields, 0 = lock active
// ***************************************************************
`define CMSL_OPT_LOCK1_BIT 0
`define CMSL_OPT_LOCK2_BIT 1
`define CMSL_OPT_RESET     8'h00
// ***************************************************************
// Verify timing
// ***************************************************************
`define CMSL_VERIFY_OSC_PERIODS 48
`define CMSL_OSC_MAX_KHZ        6000
`define CMSL_CLK_KHZ            40000
`define CMSL_VERIFY_MAX_CYC     ((`CMSL_VERIFY_OSC_PERIODS * `CMSL_CLK_KHZ) / `CMSL_OSC_MAX_KHZ)
`endif

// ---- rtl/cmsl_pkg.sv ----
`include "cmsl_regs.svh"
package cmsl_pkg;
  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    CMSL_MODE_NONE,
    CMSL_MODE_PGM_CODE,
    CMSL_MODE_PGM_KEY,
    CMSL_MODE_PGM_LOCK1,
    CMSL_MODE_PGM_LOCK2,
    CMSL_MODE_VERIFY
  } cmsl_mode_t;

  typedef enum logic [2:0] {
    CMSL_ST_BOOT0,
    CMSL_ST_BOOT,
    CMSL_ST_BOOT_LD,
    CMSL_ST_IDLE,
    CMSL_ST_TBL_LD,
    CMSL_ST_VER_CODE,
    CMSL_ST_VER_KEY
  } cmsl_fsm_t;

  typedef struct packed {
    cmsl_mode_t                   mode;
    logic [`CMSL_MEM_AW-1:0]      addr;
    logic [`CMSL_DATA_W-1:0]      data;
    logic                         strobe_b;
    logic                         ea;
  } cmsl_pins_t;

  typedef struct packed {
    cmsl_pins_t                   s1;
    cmsl_pins_t                   s2;
    logic                         strobe_q;
    cmsl_fsm_t                    st;
    logic [`CMSL_DATA_W-1:0]      opt;
    logic                         lock1;
    logic                         lock2;
    logic                         ea_latched;
    logic                         ea_eff;
    logic                         programming_strobe_pend;
    cmsl_mode_t                   programming_strobe_mode;
    logic [`CMSL_MEM_AW-1:0]      programming_strobe_addr;
    logic [`CMSL_DATA_W-1:0]      programming_strobe_data;
    logic                         programming_strobe_ok;
    logic                         programming_strobe_refused;
    logic                         tbl_pend;
    logic                         tbl_ext;
    logic [`CMSL_MEM_AW-1:0]      tbl_addr;
    logic [`CMSL_DATA_W-1:0]      tbl_data;
    logic                         tbl_valid;
    logic                         tbl_blocked;
    logic [`CMSL_MEM_AW-1:0]      ver_addr;
    logic [`CMSL_DATA_W-1:0]      code_byte;
    logic [`CMSL_DATA_W-1:0]      ver_data;
    logic                         ver_oe;
    logic                         mem_we;
    logic [`CMSL_MEM_AW-1:0]      mem_addr;
    logic [`CMSL_DATA_W-1:0]      mem_wdata;
  } cmsl_state_t;
endpackage

// ---- rtl/cmsl_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// Single port image store, registered read
// ***************************************************************
module cmsl_mem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output var  logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Erased cells read as all ones
  initial begin
    for (int i = 0; i < (1<<AW); i++) begin
      mem[i] = {DW{1'b1}};
    end
  end

  // Read returns the old byte on a write cycle
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // cmsl_mem
`default_nettype wire

// ---- rtl/cmsl_top.sv ----
// Notes on behaviour
// (RQ1) First lock blocks table reads from external code fetching internal bytes.
// (RQ2) First lock latches external access select at reset; later changes ignored.
// (RQ3) First lock refuses code and key programming; lock bits stay programmable.
// (RQ4) Second lock inhibits verify readout, on top of first lock effects.
// (RQ5) Programmer must not set second lock alone; other combinations undefined.
// (RQ6) No locks: no protection, but verify is still scrambled by key.
// (RQ7) Key array of 64 or 32 bytes, erased to all ones.
// (RQ8) Key byte all ones leaves verify byte unchanged.
// (RQ9) Option byte bit 0 first lock, bit 1 second; 0 enables.
// (RQ10) Image: code from zero, then 64-byte key, then option byte.
// (RQ11) Programmer holds strobe low 90 to 110 us, high at least 10 us.
// (RQ12) Programmer sets address and data 48 periods around strobe.
// (RQ13) Verify data valid within 48 oscillator periods of new address.
// (RQ14) Verify returns XNOR of code byte and key byte; key never readable.
// (RQ15) Programmer gives five low strobes per location or lock bit.
// (RQ16) Lock flags captured at reset gate reads, programming and verify; code and key writes also obey a first lock programmed since reset.
`timescale 1ns/1ps
`default_nettype none
`include "cmsl_regs.svh"
module cmsl_top #(
  parameter int CODE_BYTES = `CMSL_CODE_BYTES,
  parameter int KEY_BYTES  = `CMSL_KEY_BYTES
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic [2:0]              programming_strobe_mode,
  input  wire logic [`CMSL_MEM_AW-1:0] programming_strobe_addr,
  input  wire logic [`CMSL_DATA_W-1:0] programming_strobe_data,
  input  wire logic                    programming_strobe_b,
  input  wire logic                    external_access_select,
  input  wire logic                    code_table_read_req,
  input  wire logic                    code_table_read_ext,
  input  wire logic [`CMSL_MEM_AW-1:0] code_table_read_addr,
  output logic [`CMSL_DATA_W-1:0]      verify_data,
  output logic                         verify_data_oe,
  output logic [`CMSL_DATA_W-1:0]      code_table_read_data,
  output logic                         code_table_read_valid,
  output logic                         code_table_read_blocked,
  output logic                         code_table_read_busy,
  output logic                         external_access_eff,
  output logic                         first_lock_bit,
  output logic                         second_lock_bit,
  output logic                         programming_strobe_accepted,
  output logic                         programming_strobe_refused
);
  localparam logic [`CMSL_MEM_AW-1:0] KEY_MASK = `CMSL_MEM_AW'(KEY_BYTES - 1);
  localparam logic [`CMSL_MEM_AW-1:0] CODE_END = `CMSL_MEM_AW'(CODE_BYTES);

  cmsl_pkg::cmsl_state_t s;
  cmsl_pkg::cmsl_state_t next_s;
  cmsl_pkg::cmsl_pins_t  pins;
  logic [`CMSL_DATA_W-1:0] mem_rdata;
  logic                    lock1_now;
  logic                    strobe_fall;

  // ***************************************************************
  // Image store
  // ***************************************************************
  // Fed from next state so read data lands one cycle after issue
  cmsl_mem #(
    .AW (`CMSL_MEM_AW),
    .DW (`CMSL_DATA_W)
  ) u_mem (
    .clk   (clk),
    .we    (next_s.mem_we),
    .addr  (next_s.mem_addr),
    .wdata (next_s.mem_wdata),
    .rdata (mem_rdata)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  // Pin bundle for the synchroniser
  always_comb begin
    pins.mode     = cmsl_pkg::cmsl_mode_t'(programming_strobe_mode);
    pins.addr     = programming_strobe_addr;
    pins.data     = programming_strobe_data;
    pins.strobe_b = programming_strobe_b;
    pins.ea       = external_access_select;
  end

  // Lock state as it stands now, so a fresh first lock bites at once
  assign lock1_now   = s.lock1 | ~s.opt[`CMSL_OPT_LOCK1_BIT]; // see RQ3
  assign strobe_fall = s.strobe_q & ~s.s2.strobe_b;

  // Whole block: sync, programming, table reads and verify
  always_comb begin
    next_s              = s;
    next_s.s1           = pins;
    next_s.s2           = s.s1;
    next_s.strobe_q     = s.s2.strobe_b;
    next_s.mem_we       = 1'b0;
    next_s.programming_strobe_ok      = 1'b0;
    next_s.programming_strobe_refused = 1'b0;
    next_s.tbl_valid    = 1'b0;
    // Every strobe fall outside none and verify modes is one write attempt; repeated pulses rewrite the same byte
    if (strobe_fall && s.s2.mode != cmsl_pkg::CMSL_MODE_VERIFY
        && s.s2.mode != cmsl_pkg::CMSL_MODE_NONE) begin // see RQ15
      next_s.programming_strobe_pend = 1'b1;
      next_s.programming_strobe_mode = s.s2.mode;
      next_s.programming_strobe_addr = s.s2.addr;
      next_s.programming_strobe_data = s.s2.data;
    end
    // A request while one is pending is dropped
    if (code_table_read_req && !s.tbl_pend) begin
      next_s.tbl_pend = 1'b1;
      next_s.tbl_ext  = code_table_read_ext;
      next_s.tbl_addr = code_table_read_addr;
    end
    // Follow the pin unless the first lock froze it at reset
    next_s.ea_eff = s.lock1 ? s.ea_latched : s.s2.ea; // see RQ2
    case (s.st)
      cmsl_pkg::CMSL_ST_BOOT0: begin
        next_s.st = cmsl_pkg::CMSL_ST_BOOT;
      end
      cmsl_pkg::CMSL_ST_BOOT: begin
        next_s.mem_addr = `CMSL_OPT_ADDR; // see RQ10
        next_s.st       = cmsl_pkg::CMSL_ST_BOOT_LD;
      end
      cmsl_pkg::CMSL_ST_BOOT_LD: begin
        // Flags held until the next reset
        next_s.opt        = mem_rdata;
        next_s.lock1      = ~mem_rdata[`CMSL_OPT_LOCK1_BIT]; // see RQ9, RQ16
        next_s.lock2      = ~mem_rdata[`CMSL_OPT_LOCK2_BIT]; // see RQ9, RQ16
        next_s.ea_latched = s.s2.ea; // see RQ2
        next_s.st         = cmsl_pkg::CMSL_ST_IDLE;
      end
      cmsl_pkg::CMSL_ST_IDLE: begin
        if (s.s2.mode != cmsl_pkg::CMSL_MODE_VERIFY) begin
          next_s.ver_oe = 1'b0;
        end
        if (s.programming_strobe_pend) begin
          next_s.programming_strobe_pend = strobe_fall && next_s.programming_strobe_pend;
          next_s.mem_wdata = s.programming_strobe_data;
          next_s.mem_addr  = s.programming_strobe_addr;
          case (s.programming_strobe_mode)
            cmsl_pkg::CMSL_MODE_PGM_CODE: begin
              next_s.mem_we = !lock1_now && s.programming_strobe_addr < CODE_END; // see RQ3
            end
            cmsl_pkg::CMSL_MODE_PGM_KEY: begin
              next_s.mem_addr = `CMSL_KEY_BASE | (s.programming_strobe_addr & KEY_MASK); // see RQ7
              next_s.mem_we   = !lock1_now; // see RQ3
            end
            cmsl_pkg::CMSL_MODE_PGM_LOCK1: begin
              next_s.mem_addr                        = `CMSL_OPT_ADDR;
              next_s.mem_wdata                       = s.opt;
              next_s.mem_wdata[`CMSL_OPT_LOCK1_BIT]  = 1'b0;
              next_s.opt[`CMSL_OPT_LOCK1_BIT]        = 1'b0;
              next_s.mem_we                          = 1'b1;
            end
            cmsl_pkg::CMSL_MODE_PGM_LOCK2: begin
              // Left to the programmer to pair it with the first lock
              next_s.mem_addr                        = `CMSL_OPT_ADDR; // see RQ5
              next_s.mem_wdata                       = s.opt;
              next_s.mem_wdata[`CMSL_OPT_LOCK2_BIT]  = 1'b0;
              next_s.opt[`CMSL_OPT_LOCK2_BIT]        = 1'b0;
              next_s.mem_we                          = 1'b1;
            end
            default: begin
              next_s.mem_we = 1'b0;
            end
          endcase
          next_s.programming_strobe_ok      = next_s.mem_we;
          next_s.programming_strobe_refused = !next_s.mem_we;
        end else if (s.tbl_pend) begin
          next_s.mem_addr = s.tbl_addr;
          next_s.st       = cmsl_pkg::CMSL_ST_TBL_LD;
        end else if (s.s2.mode == cmsl_pkg::CMSL_MODE_VERIFY) begin
          // Short loop keeps readout far inside the verify deadline
          next_s.ver_addr = s.s2.addr; // see RQ13
          next_s.mem_addr = s.s2.addr;
          next_s.st       = cmsl_pkg::CMSL_ST_VER_CODE;
        end
      end
      cmsl_pkg::CMSL_ST_TBL_LD: begin
        // A request seen here met a busy block and was dropped, so nothing pends
        next_s.tbl_pend    = 1'b0;
        next_s.tbl_valid   = 1'b1;
        // Key and option bytes never leave through a table read
        next_s.tbl_blocked = (s.lock1 && s.tbl_ext) || s.tbl_addr >= CODE_END; // see RQ1, RQ14
        next_s.tbl_data    = next_s.tbl_blocked ? `CMSL_BLOCKED_BYTE : mem_rdata; // see RQ1
        next_s.st          = cmsl_pkg::CMSL_ST_IDLE;
      end
      cmsl_pkg::CMSL_ST_VER_CODE: begin
        next_s.code_byte = mem_rdata;
        next_s.mem_addr  = `CMSL_KEY_BASE | (s.ver_addr & KEY_MASK); // see RQ14
        next_s.st        = cmsl_pkg::CMSL_ST_VER_KEY;
      end
      cmsl_pkg::CMSL_ST_VER_KEY: begin
        next_s.ver_oe   = !s.lock2 && s.ver_addr < CODE_END
                          && s.s2.mode == cmsl_pkg::CMSL_MODE_VERIFY; // see RQ4, RQ14
        // Erased key is all ones, so the XNOR passes code unchanged
        // Hidden bytes park at zero so the port register never holds them
        next_s.ver_data = next_s.ver_oe ? ~(s.code_byte ^ mem_rdata)
                                        : `CMSL_BLOCKED_BYTE; // see RQ6, RQ8, RQ14
        next_s.st       = cmsl_pkg::CMSL_ST_IDLE;
      end
      default: begin
        next_s.st = cmsl_pkg::CMSL_ST_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Reset image is all zero: option zero reads as locked until boot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign verify_data             = s.ver_data;
  assign verify_data_oe          = s.ver_oe;
  assign code_table_read_data    = s.tbl_data;
  assign code_table_read_valid   = s.tbl_valid;
  assign code_table_read_blocked = s.tbl_blocked;
  assign code_table_read_busy    = s.tbl_pend;
  assign external_access_eff     = s.ea_eff;
  assign first_lock_bit          = s.lock1;
  assign second_lock_bit         = s.lock2;
  assign programming_strobe_accepted           = s.programming_strobe_ok;
  assign programming_strobe_refused            = s.programming_strobe_refused;
endmodule // cmsl_top
`default_nettype wire

// ---- rtl/cmsl_top_unused.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- verif/cmsl_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// *****************************************
// Port-level checks of the lock logic
// *****************************************
module cmsl_top_asserts #(
  parameter int CODE_BYTES = 4096,
  parameter int KEY_BYTES  = 64
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [2:0]  programming_strobe_mode,
  input wire logic        code_table_read_req,
  input wire logic        code_table_read_ext,
  input wire logic [12:0] code_table_read_addr,
  input wire logic [7:0]  code_table_read_data,
  input wire logic        code_table_read_valid,
  input wire logic        code_table_read_blocked,
  input wire logic        code_table_read_busy,
  input wire logic        verify_data_oe,
  input wire logic        external_access_eff,
  input wire logic        first_lock_bit,
  input wire logic        second_lock_bit,
  input wire logic        programming_strobe_accepted,
  input wire logic        programming_strobe_refused
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic        ext_q;
  logic [12:0] addr_q;
  logic [3:0]  run_cnt;
  // Keep the taken request so its answer is judged against its own cause
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_q   <= 1'b0;
      addr_q  <= 13'h0000;
      run_cnt <= 4'h0;
    end else begin
      run_cnt <= run_cnt + {3'h0, run_cnt != 4'hF};
      if (code_table_read_req && !code_table_read_busy) begin
        ext_q  <= code_table_read_ext;
        addr_q <= code_table_read_addr;
      end
    end
  end
  sequence s_take; code_table_read_req && !code_table_read_busy; endsequence
  sequence s_ans; programming_strobe_accepted || programming_strobe_refused; endsequence
  property p_tbl_answer; s_take |-> ##[1:40] code_table_read_valid; endproperty
  a_tbl_answer: assert property (p_tbl_answer) else $error("table read unanswered");
  property p_tbl_block;
    code_table_read_valid |-> code_table_read_blocked == ((first_lock_bit && ext_q) || addr_q >= CODE_BYTES);
  endproperty
  a_tbl_block: assert property (p_tbl_block) else $error("table read block wrong");
  property p_blk_zero; code_table_read_valid && code_table_read_blocked |-> code_table_read_data == 8'h00; endproperty
  a_blk_zero: assert property (p_blk_zero) else $error("blocked read leaks data");
  property p_ea_hold; first_lock_bit && $past(first_lock_bit) |-> $stable(external_access_eff); endproperty
  a_ea_hold: assert property (p_ea_hold) else $error("latched access level moved");
  property p_flags_fixed; run_cnt == 4'hF |-> $stable(first_lock_bit) && $stable(second_lock_bit); endproperty
  a_flags_fixed: assert property (p_flags_fixed) else $error("lock flag moved after boot");
  property p_ver_lock2; second_lock_bit |-> !verify_data_oe; endproperty
  a_ver_lock2: assert property (p_ver_lock2) else $error("verify shown under lock");
  property p_lock_refuse; programming_strobe_accepted && first_lock_bit |-> programming_strobe_mode inside {3'h3, 3'h4}; endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("write taken under lock");
  property p_one_answer; s_ans |-> !(programming_strobe_accepted && programming_strobe_refused) ##1 !(programming_strobe_accepted || programming_strobe_refused); endproperty
  a_one_answer: assert property (p_one_answer) else $error("strobe answer not single");
endmodule // cmsl_top_asserts
bind cmsl_top cmsl_top_asserts #(.CODE_BYTES(CODE_BYTES), .KEY_BYTES(KEY_BYTES)) cmsl_top_asserts_i (
  .clk, .rst_b, .programming_strobe_mode, .code_table_read_req, .code_table_read_ext, .code_table_read_addr,
  .code_table_read_data, .code_table_read_valid, .code_table_read_blocked, .code_table_read_busy,
  .verify_data_oe, .external_access_eff, .first_lock_bit, .second_lock_bit, .programming_strobe_accepted, .programming_strobe_refused);
`default_nettype wire

// ---- verif/cmsl_programming_strobe_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// *****************************************
// Programmer, strobe timing scaled down
// *****************************************
module cmsl_programming_strobe_model #(
  parameter int LOW_CYC   = 8,
  parameter int HIGH_CYC  = 4,
  parameter int SETUP_CYC = 8
) (
  input  wire logic   clk,
  output logic [2:0]  programming_strobe_mode,
  output logic [12:0] programming_strobe_addr,
  output logic [7:0]  programming_strobe_data,
  output logic        programming_strobe_b
);
  // Idle pins from time zero
  initial begin
    programming_strobe_mode = 3'h0;
    programming_strobe_addr = 13'h0000;
    programming_strobe_data = 8'h00;
    programming_strobe_b = 1'b1;
  end
  // Five strobes per location, pins held around each one
  task automatic pgm(input logic [2:0] m, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    programming_strobe_mode <= m;
    programming_strobe_addr <= a;
    programming_strobe_data <= d;
    repeat (5) begin
      repeat (SETUP_CYC) @(posedge clk);
      programming_strobe_b <= 1'b0;
      repeat (LOW_CYC) @(posedge clk);
      programming_strobe_b <= 1'b1;
      repeat (HIGH_CYC) @(posedge clk);
    end
    repeat (SETUP_CYC) @(posedge clk);
    // Released address and data flip and mode drops to none, so a stale value never passes
    programming_strobe_mode <= 3'h0;
    programming_strobe_addr <= ~a;
    programming_strobe_data <= ~d;
  endtask
  // Verify: address set and data flipped, strobe stays high
  task automatic vset(input logic [12:0] a);
    @(posedge clk);
    programming_strobe_mode <= 3'h5;
    programming_strobe_addr <= a;
    programming_strobe_data <= ~programming_strobe_data;
  endtask
endmodule // cmsl_programming_strobe_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  // *****************************************
  // Wiring, clock, bookkeeping
  // *****************************************
  logic        clk, rst_b, programming_strobe_b, external_access_select, verify_data_oe;
  logic        code_table_read_req, code_table_read_ext, code_table_read_valid, code_table_read_blocked;
  logic        code_table_read_busy, external_access_eff, first_lock_bit, second_lock_bit;
  logic        programming_strobe_accepted, programming_strobe_refused;
  logic [2:0]  programming_strobe_mode;
  logic [12:0] programming_strobe_addr, code_table_read_addr, a;
  logic [7:0]  programming_strobe_data, verify_data, code_table_read_data, code_m [4096], key_m [64];
  int          err_count, checks, nacc, nref;
  cmsl_top cmsl_top_i (.clk, .rst_b, .programming_strobe_mode, .programming_strobe_addr, .programming_strobe_data, .programming_strobe_b,
    .external_access_select, .code_table_read_req, .code_table_read_ext, .code_table_read_addr,
    .verify_data, .verify_data_oe, .code_table_read_data, .code_table_read_valid, .code_table_read_blocked,
    .code_table_read_busy, .external_access_eff, .first_lock_bit, .second_lock_bit, .programming_strobe_accepted,
    .programming_strobe_refused);
  cmsl_programming_strobe_model #(.LOW_CYC(8), .HIGH_CYC(4), .SETUP_CYC(8)) cmsl_programming_strobe_model_i (.clk, .programming_strobe_mode,
    .programming_strobe_addr, .programming_strobe_data, .programming_strobe_b);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // One-cycle answers counted on the settled edge
  always @(negedge clk) begin
    nacc += int'(programming_strobe_accepted === 1'b1);
    nref += int'(programming_strobe_refused === 1'b1);
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tmo();
    err_count++;
    $display("BAD t=%0t wait ran out", $time);
    final_report();
  endtask
  task automatic do_reset(input logic ea);
    rst_b <= 1'b0;
    external_access_select <= ea;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // Five strobes: all accepted or all refused
  task automatic pg(input logic [2:0] m, input logic [12:0] ad, input logic [7:0] d, input logic ok);
    int n0;
    n0 = ok ? nacc : nref;
    cmsl_programming_strobe_model_i.pgm(m, ad, d);
    chk(16'((ok ? nacc : nref) - n0), 16'h0005);
    if (ok && m == 3'h1) code_m[ad[11:0]] = d;
    if (ok && m == 3'h2) key_m[ad[5:0]] = d;
  endtask
  // Expected verify byte: code XNOR key, key picked by the low address bits
  function automatic logic [7:0] exp_ver(input logic [12:0] ad);
    return ~(code_m[ad[11:0]] ^ key_m[ad[5:0]]);
  endfunction
  task automatic tr(input logic ext, input logic [12:0] ad, input logic blk);
    @(posedge clk);
    code_table_read_req <= 1'b1;
    code_table_read_ext <= ext;
    code_table_read_addr <= ad;
    @(posedge clk);
    code_table_read_req <= 1'b0;
    for (int i = 0; i <= 40; i++) begin
      @(negedge clk);
      if (i == 0) chk({15'h0000, code_table_read_busy}, 16'h0001);
      if (code_table_read_valid === 1'b1) break;
      if (i == 40) tmo();
    end
    chk({7'h00, code_table_read_blocked, code_table_read_data}, {7'h00, blk, blk ? 8'h00 : code_m[ad[11:0]]});
    chk({15'h0000, code_table_read_busy}, 16'h0000);
  endtask
  // Bounded by the 48-period allowance at the fastest oscillator
  task automatic ver(input logic [12:0] ad, input logic oe);
    logic [7:0] e;
    e = exp_ver(ad);
    cmsl_programming_strobe_model_i.vset(ad);
    if (!oe) repeat (40) @(negedge clk);
    for (int i = 0; i <= 320; i++) begin
      @(negedge clk);
      if (verify_data_oe === oe && (!oe || verify_data === e)) break;
      if (i == 320) tmo();
    end
    chk({7'h00, verify_data_oe, verify_data}, {7'h00, oe, oe ? e : 8'h00});
  endtask
  initial begin
    code_table_read_req = 1'b0;
    code_table_read_ext = 1'b0;
    code_table_read_addr = 13'h0000;
    foreach (code_m[i]) code_m[i] = 8'hFF;
    foreach (key_m[i]) key_m[i] = 8'hFF;
    void'($urandom(96));
    do_reset(1'b0);
    chk({14'h0000, first_lock_bit, second_lock_bit}, 16'h0000);
    // Ends of the user area and random spots, key still erased
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h0FFF : 13'($urandom_range(4095));
      pg(3'h1, a, 8'($urandom), 1'b1);
      ver(a, 1'b1);
      tr(1'b1, a, 1'b0);
    end
    pg(3'h1, 13'h1000, 8'h5A, 1'b0);
    $display("test plain code done");
    pg(3'h2, 13'h003F, 8'($urandom), 1'b1);
    pg(3'h2, {7'h00, a[5:0]}, 8'($urandom), 1'b1);
    ver(13'h0FFF, 1'b1);
    ver(a, 1'b1);
    ver(13'h1000, 1'b0);
    tr(1'b0, 13'h1000, 1'b1);
    $display("test key done");
    pg(3'h3, 13'h1040, 8'h00, 1'b1);
    pg(3'h1, 13'h0010, 8'h00, 1'b0);
    pg(3'h4, 13'h1040, 8'h00, 1'b1);
    chk({14'h0000, first_lock_bit, second_lock_bit}, 16'h0000);
    $display("test lock writes done");
    do_reset(1'b1);
    chk({13'h0000, first_lock_bit, second_lock_bit, external_access_eff}, 16'h0007);
    external_access_select <= 1'b0;
    repeat (10) @(posedge clk);
    chk({15'h0000, external_access_eff}, 16'h0001);
    tr(1'b0, 13'h0FFF, 1'b0);
    ver(13'h0FFF, 1'b0);
    pg(3'h2, 13'h0001, 8'h00, 1'b0);
    pg(3'h4, 13'h1040, 8'h00, 1'b1);
    for (int i = 0; i < 6; i++) begin
      a = 13'($urandom);
      tr(a[12] ^ a[0], a, a[12] | (a[12] ^ a[0]));
    end
    $display("test locked part done");
    final_report();
  end
endmodule // tb
`default_nettype wire
